// File: rtl/bst_tap.sv
// Purpose: boundary-scan test access port with controller and scan paths
// Assumes: test_clock_in is the link clock, core_clk_in the system clock
// Notes: update latches and serial out change on the falling test clock;
// feature select and pin samples pass two test-clock flops first;
// only flops cross toward the core clock, the word under a toggle

`timescale 1ns/1ps

module bst_tap (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic test_clock_in,
	input wire logic test_reset_n_in,
	input wire logic test_mode_select_in,
	input wire logic test_serial_in_in,
	input wire logic feature_set_select_in,
	input wire logic [bst_pkg::BSR_W-1:0] pin_sample_in,
	output logic test_serial_out_out,
	output logic test_serial_out_oe_out,
	output logic [bst_pkg::BSR_W-1:0] bsr_drive_out,
	output logic pin_override_out,
	output logic pin_highz_out
);

	////////////////////////////////////////////////////////////////////////
	// decoding

	function automatic bst_pkg::bst_sel_t sel_of(
		input logic [bst_pkg::IR_W-1:0] ins
	);
		bst_pkg::bst_sel_t s;
		s = bst_pkg::SEL_BYPASS;
		case (ins)
			bst_pkg::INS_EXTEST: s = bst_pkg::SEL_BSR;
			bst_pkg::INS_SAMPLE: s = bst_pkg::SEL_BSR;
			bst_pkg::INS_IDCODE: s = bst_pkg::SEL_ID;
			// clamp, highz, bypass and unused codes use bypass
			default: s = bst_pkg::SEL_BYPASS;
		endcase
		return s;
	endfunction : sel_of

	////////////////////////////////////////////////////////////////////////
	// instruction and state decodes

	// boundary register captures and updates only for these two codes
	function automatic logic loads_bsr(
		input logic [bst_pkg::IR_W-1:0] ins
	);
		return (ins == bst_pkg::INS_SAMPLE) ||
			(ins == bst_pkg::INS_EXTEST);
	endfunction : loads_bsr

	// pins take the boundary parallel word; clamp holds it unchanged
	function automatic logic overrides_pins(
		input logic [bst_pkg::IR_W-1:0] ins
	);
		return (ins == bst_pkg::INS_EXTEST) ||
			(ins == bst_pkg::INS_CLAMP);
	endfunction : overrides_pins

	// system outputs released, not driven
	function automatic logic floats_pins(
		input logic [bst_pkg::IR_W-1:0] ins
	);
		return ins == bst_pkg::INS_HIGHZ;
	endfunction : floats_pins

	// serial out enabled only while a register sits in the path
	function automatic logic is_shift(
		input bst_pkg::bst_state_t st
	);
		return (st == bst_pkg::ST_SHIFT_IR) ||
			(st == bst_pkg::ST_SHIFT_DR);
	endfunction : is_shift

	function automatic bst_pkg::bst_state_t next_of(
		input bst_pkg::bst_state_t st,
		input logic tms
	);
		bst_pkg::bst_state_t n;
		n = bst_pkg::ST_RESET;
		case (st)
			bst_pkg::ST_RESET:
				n = tms ? bst_pkg::ST_RESET : bst_pkg::ST_IDLE;
			bst_pkg::ST_IDLE:
				n = tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
			bst_pkg::ST_SEL_DR:
				n = tms ? bst_pkg::ST_SEL_IR : bst_pkg::ST_CAP_DR;
			bst_pkg::ST_CAP_DR:
				n = tms ? bst_pkg::ST_EXIT1_DR : bst_pkg::ST_SHIFT_DR;
			bst_pkg::ST_SHIFT_DR:
				n = tms ? bst_pkg::ST_EXIT1_DR : bst_pkg::ST_SHIFT_DR;
			bst_pkg::ST_EXIT1_DR:
				n = tms ? bst_pkg::ST_UPD_DR : bst_pkg::ST_PAUSE_DR;
			bst_pkg::ST_PAUSE_DR:
				n = tms ? bst_pkg::ST_EXIT2_DR : bst_pkg::ST_PAUSE_DR;
			bst_pkg::ST_EXIT2_DR:
				n = tms ? bst_pkg::ST_UPD_DR : bst_pkg::ST_SHIFT_DR;
			bst_pkg::ST_UPD_DR:
				n = tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
			bst_pkg::ST_SEL_IR:
				n = tms ? bst_pkg::ST_RESET : bst_pkg::ST_CAP_IR;
			bst_pkg::ST_CAP_IR:
				n = tms ? bst_pkg::ST_EXIT1_IR : bst_pkg::ST_SHIFT_IR;
			bst_pkg::ST_SHIFT_IR:
				n = tms ? bst_pkg::ST_EXIT1_IR : bst_pkg::ST_SHIFT_IR;
			bst_pkg::ST_EXIT1_IR:
				n = tms ? bst_pkg::ST_UPD_IR : bst_pkg::ST_PAUSE_IR;
			bst_pkg::ST_PAUSE_IR:
				n = tms ? bst_pkg::ST_EXIT2_IR : bst_pkg::ST_PAUSE_IR;
			bst_pkg::ST_EXIT2_IR:
				n = tms ? bst_pkg::ST_UPD_IR : bst_pkg::ST_SHIFT_IR;
			bst_pkg::ST_UPD_IR:
				n = tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
			default:
				n = bst_pkg::ST_RESET;
		endcase
		return n;
	endfunction : next_of

	////////////////////////////////////////////////////////////////////////
	// rising test clock: controller and shift stages

	typedef struct packed {
		bst_pkg::bst_state_t state;
		logic feat_s1;
		logic feat_s2;
		logic [bst_pkg::BSR_W-1:0] pin_s1;
		logic [bst_pkg::BSR_W-1:0] pin_s2;
		logic [bst_pkg::IR_W-1:0] ir_sh;
		logic byp_sh;
		logic [bst_pkg::ID_W-1:0] id_sh;
		logic [bst_pkg::BSR_W-1:0] bsr_sh;
	} bst_rise_t;

	// falling test clock: update latches and serial out
	typedef struct packed {
		logic [bst_pkg::IR_W-1:0] ir_par;
		logic [bst_pkg::BSR_W-1:0] bsr_par;
		logic upd_tgl;
		logic tdo;
		logic tdo_oe;
		// decodes kept as flops so the core never sees a comparator
		logic ovr;
		logic hz;
	} bst_fall_t;

	// core clock: crossings toward the system side
	typedef struct packed {
		logic tgl_s1;
		logic tgl_s2;
		logic tgl_prev;
		logic ovr_s1;
		logic ovr_s2;
		logic hz_s1;
		logic hz_s2;
		logic [bst_pkg::BSR_W-1:0] drive;
	} bst_core_t;

	localparam bst_rise_t RISE_RESET = '{
		state: bst_pkg::ST_RESET,
		feat_s1: 1'b0,
		feat_s2: 1'b0,
		pin_s1: bst_pkg::BSR_RESET,
		pin_s2: bst_pkg::BSR_RESET,
		ir_sh: bst_pkg::IR_CAPTURE,
		byp_sh: bst_pkg::BYPASS_CAPTURE,
		id_sh: bst_pkg::IDCODE_VALUE,
		bsr_sh: bst_pkg::BSR_RESET
	};

	localparam bst_fall_t FALL_RESET = '{
		ir_par: bst_pkg::INS_IDCODE,
		bsr_par: bst_pkg::BSR_RESET,
		upd_tgl: 1'b0,
		tdo: 1'b0,
		tdo_oe: 1'b0,
		ovr: 1'b0,
		hz: 1'b0
	};

	localparam bst_core_t CORE_RESET = '{
		tgl_s1: 1'b0,
		tgl_s2: 1'b0,
		tgl_prev: 1'b0,
		ovr_s1: 1'b0,
		ovr_s2: 1'b0,
		hz_s1: 1'b0,
		hz_s2: 1'b0,
		drive: bst_pkg::BSR_RESET
	};

	bst_rise_t r_r;
	bst_rise_t r_nxt;
	bst_fall_t f_r;
	bst_fall_t f_nxt;
	bst_core_t c_r;
	bst_core_t c_nxt;
	bst_pkg::bst_sel_t sel;
	logic bsr_load_ok;

	// both read the falling-edge latch: half a period of settling
	assign sel = sel_of(f_r.ir_par);
	// only sample and extest let the boundary register load or update
	assign bsr_load_ok = loads_bsr(f_r.ir_par);

	////////////////////////////////////////////////////////////////////////

	// rising edge: state, capture and shift
	always_comb
	begin
		r_nxt = r_r;
		// two flops on the test clock; capture sees pins two edges late,
		// a change inside that span is missed by the capture
		r_nxt.feat_s1 = feature_set_select_in;
		r_nxt.feat_s2 = r_r.feat_s1;
		r_nxt.pin_s1 = pin_sample_in;
		r_nxt.pin_s2 = r_r.pin_s1;
		// idle, select, pause, exit and update states hold all shift registers; the sync flops still move
		case (r_r.state)
			bst_pkg::ST_CAP_DR:
			begin
				case (sel)
					bst_pkg::SEL_BSR:
						if (bsr_load_ok)
						begin
							r_nxt.bsr_sh = r_r.pin_s2;
						end
					bst_pkg::SEL_ID:
						r_nxt.id_sh = bst_pkg::IDCODE_VALUE;
					default:
						r_nxt.byp_sh = bst_pkg::BYPASS_CAPTURE;
				endcase
			end
			bst_pkg::ST_SHIFT_DR:
			begin
				case (sel)
					bst_pkg::SEL_BSR:
						r_nxt.bsr_sh = {test_serial_in_in,
							r_r.bsr_sh[bst_pkg::BSR_W-1:1]};
					bst_pkg::SEL_ID:
						r_nxt.id_sh = {test_serial_in_in,
							r_r.id_sh[bst_pkg::ID_W-1:1]};
					default:
						r_nxt.byp_sh = test_serial_in_in;
				endcase
			end
			bst_pkg::ST_CAP_IR:
				r_nxt.ir_sh = bst_pkg::IR_CAPTURE;
			bst_pkg::ST_SHIFT_IR:
				r_nxt.ir_sh = {test_serial_in_in,
					r_r.ir_sh[bst_pkg::IR_W-1:1]};
			default:
				r_nxt.ir_sh = r_r.ir_sh;
		endcase
		// emulation mode parks the controller in reset
		if (r_r.feat_s2 != bst_pkg::FEATURE_NATIVE)
		begin
			r_nxt.state = bst_pkg::ST_RESET;
		end
		else
		begin
			r_nxt.state = next_of(r_r.state, test_mode_select_in);
		end
	end

	// test reset is asynchronous and needs no test clock
	always_ff @(posedge test_clock_in or negedge test_reset_n_in)
	begin
		if (!test_reset_n_in)
		begin
			r_r <= RISE_RESET;
		end
		else
		begin
			r_r <= r_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////

	// falling edge: update latches, serial out and decodes
	always_comb
	begin
		f_nxt = f_r;
		case (r_r.state)
			bst_pkg::ST_RESET:
				f_nxt.ir_par = bst_pkg::INS_IDCODE;
			bst_pkg::ST_UPD_IR:
				f_nxt.ir_par = r_r.ir_sh;
			bst_pkg::ST_UPD_DR:
			begin
				if (sel == bst_pkg::SEL_BSR && bsr_load_ok)
				begin
					f_nxt.bsr_par = r_r.bsr_sh;
					// a level change, not a pulse, so it survives the crossing
					f_nxt.upd_tgl = ~f_r.upd_tgl;
				end
			end
			default:
				f_nxt.ir_par = f_r.ir_par;
		endcase
		f_nxt.tdo_oe = is_shift(r_r.state);
		if (r_r.state == bst_pkg::ST_SHIFT_IR)
		begin
			f_nxt.tdo = r_r.ir_sh[0];
		end
		else
		begin
			case (sel)
				bst_pkg::SEL_BSR: f_nxt.tdo = r_r.bsr_sh[0];
				bst_pkg::SEL_ID: f_nxt.tdo = r_r.id_sh[0];
				default: f_nxt.tdo = r_r.byp_sh;
			endcase
		end
		// decoded from the next code so they move with the latch
		f_nxt.ovr = overrides_pins(f_nxt.ir_par);
		f_nxt.hz = floats_pins(f_nxt.ir_par);
	end

	// serial out moves half a period after the shift edge, so the
	// tester always has half a period of hold at its rising edge
	always_ff @(negedge test_clock_in or negedge test_reset_n_in)
	begin
		if (!test_reset_n_in)
		begin
			f_r <= FALL_RESET;
		end
		else
		begin
			f_r <= f_nxt;
		end
	end

	assign test_serial_out_out = f_r.tdo;
	assign test_serial_out_oe_out = f_r.tdo_oe;

	////////////////////////////////////////////////////////////////////////
	// the latched word is stable for many test clocks after each toggle,
	// so taking it on the synchronised toggle edge is safe
	// limitation: a test reset clears the toggle; if it was set, the
	// core takes the cleared latch once, which matches the reset state

	always_comb
	begin
		c_nxt = c_r;
		c_nxt.tgl_s1 = f_r.upd_tgl;
		c_nxt.tgl_s2 = c_r.tgl_s1;
		c_nxt.tgl_prev = c_r.tgl_s2;
		c_nxt.ovr_s1 = f_r.ovr;
		c_nxt.ovr_s2 = c_r.ovr_s1;
		c_nxt.hz_s1 = f_r.hz;
		c_nxt.hz_s2 = c_r.hz_s1;
		if (c_r.tgl_s2 != c_r.tgl_prev)
		begin
			c_nxt.drive = f_r.bsr_par;
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			c_r <= CORE_RESET;
		end
		else
		begin
			c_r <= c_nxt;
		end
	end

	assign bsr_drive_out = c_r.drive;
	assign pin_override_out = c_r.ovr_s2;
	assign pin_highz_out = c_r.hz_s2;

endmodule : bst_tap

// File: rtl/bst_pkg.sv
// Purpose: constants and types of the boundary-scan test access port
// Assumes: 3-bit instruction register, 126-cell boundary register
// Notes: identification fields are arbitrary neutral values

package bst_pkg;

	localparam int IR_W = 3;
	localparam int BSR_W = 126;
	localparam int ID_W = 32;

	localparam logic [IR_W-1:0] INS_EXTEST = 3'h0;
	localparam logic [IR_W-1:0] INS_IDCODE = 3'h1;
	localparam logic [IR_W-1:0] INS_SAMPLE = 3'h2;
	localparam logic [IR_W-1:0] INS_CLAMP = 3'h3;
	localparam logic [IR_W-1:0] INS_HIGHZ = 3'h4;
	localparam logic [IR_W-1:0] INS_BYPASS = 3'h7;

	// fixed pattern loaded in Capture-IR
	localparam logic [IR_W-1:0] IR_CAPTURE = 3'h1;

	// identification fields; values arbitrary
	localparam logic [3:0] ID_VERSION = 4'h0;
	localparam logic [15:0] ID_DEVICE = 16'hA5C3;
	localparam logic [10:0] ID_MAKER = 11'h2AB;
	localparam logic [ID_W-1:0] IDCODE_VALUE =
		{ID_VERSION, ID_DEVICE, ID_MAKER, 1'b1};

	localparam logic BYPASS_CAPTURE = 1'b0;
	localparam logic [BSR_W-1:0] BSR_RESET = {BSR_W{1'b0}};
	localparam logic FEATURE_NATIVE = 1'b0;

	typedef enum logic [15:0] {
		ST_RESET = 16'h0001,
		ST_IDLE = 16'h0002,
		ST_SEL_DR = 16'h0004,
		ST_CAP_DR = 16'h0008,
		ST_SHIFT_DR = 16'h0010,
		ST_EXIT1_DR = 16'h0020,
		ST_PAUSE_DR = 16'h0040,
		ST_EXIT2_DR = 16'h0080,
		ST_UPD_DR = 16'h0100,
		ST_SEL_IR = 16'h0200,
		ST_CAP_IR = 16'h0400,
		ST_SHIFT_IR = 16'h0800,
		ST_EXIT1_IR = 16'h1000,
		ST_PAUSE_IR = 16'h2000,
		ST_EXIT2_IR = 16'h4000,
		ST_UPD_IR = 16'h8000
	} bst_state_t;

	typedef enum logic [2:0] {
		SEL_BYPASS = 3'h1,
		SEL_BSR = 3'h2,
		SEL_ID = 3'h4
	} bst_sel_t;

endpackage : bst_pkg

// File: tb/bst_tap_checker.sv
// Purpose: port-level checks of the test access port
// Assumes: tester moves mode select just after a falling test clock
// Notes: enable and serial out settle on the falling edge
`timescale 1ns/1ps
module bst_tap_checker (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic test_clock_in,
	input wire logic test_reset_n_in,
	input wire logic test_mode_select_in,
	input wire logic feature_set_select_in,
	input wire logic test_serial_out_out,
	input wire logic test_serial_out_oe_out,
	input wire logic pin_override_out,
	input wire logic pin_highz_out
);
	wire logic tms = test_mode_select_in;
	wire logic oe = test_serial_out_oe_out;
////////////////////////////////////////////////////////////////////////////
	sequence s_idle;
		tms [*5] ##1 !tms;
	endsequence
	sequence s_pause_back;
		oe && tms ##1 !tms ##1 tms ##1 !tms;
	endsequence
	sequence s_upd_dr;
		oe && tms ##1 tms [*2] ##1 !tms [*2];
	endsequence
	property p_tlr;
		@(posedge test_clock_in) disable iff (!test_reset_n_in)
		tms [*5] |=> !oe;
	endproperty
	a_tlr: assert property (p_tlr)
		else $error("serial out enabled after reset walk");
	property p_ir;
		@(posedge test_clock_in) disable iff (!test_reset_n_in)
		s_idle ##1 tms [*2] ##1 !tms [*2] |=> oe && test_serial_out_out;
	endproperty
	a_ir: assert property (p_ir)
		else $error("instruction shift not entered with capture bit");
	property p_dr;
		@(posedge test_clock_in) disable iff (!test_reset_n_in)
		s_idle ##1 tms ##1 !tms [*2] |=> oe && test_serial_out_out;
	endproperty
	a_dr: assert property (p_dr)
		else $error("data shift not entered with id lsb");
	property p_stay;
		@(posedge test_clock_in) disable iff (!test_reset_n_in)
		oe |=> oe == !$past(tms);
	endproperty
	a_stay: assert property (p_stay)
		else $error("shift state left or kept wrongly");
	property p_exit2;
		@(posedge test_clock_in) disable iff (!test_reset_n_in)
		s_pause_back |=> oe;
	endproperty
	a_exit2: assert property (p_exit2)
		else $error("pause path did not return to shift");
	property p_upd;
		@(posedge test_clock_in) disable iff (!test_reset_n_in)
		s_upd_dr |=> oe;
	endproperty
	a_upd: assert property (p_upd)
		else $error("update with mode high did not reach data scan");
	property p_fss;
		@(posedge test_clock_in) disable iff (!test_reset_n_in)
		feature_set_select_in [*5] |-> !oe;
	endproperty
	a_fss: assert property (p_fss)
		else $error("port drives while disabled");
	property p_excl;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		!(pin_override_out && pin_highz_out);
	endproperty
	a_excl: assert property (p_excl)
		else $error("override and high impedance together");
endmodule : bst_tap_checker

bind bst_tap bst_tap_checker u_chk (
	.core_clk_in(core_clk_in),
	.rst_n_in(rst_n_in),
	.test_clock_in(test_clock_in),
	.test_reset_n_in(test_reset_n_in),
	.test_mode_select_in(test_mode_select_in),
	.feature_set_select_in(feature_set_select_in),
	.test_serial_out_out(test_serial_out_out),
	.test_serial_out_oe_out(test_serial_out_oe_out),
	.pin_override_out(pin_override_out),
	.pin_highz_out(pin_highz_out)
);

// File: tb/bst_tester.sv
// Purpose: behavioural boundary-scan tester driving the link
// Assumes: scans start from Run-Test-Idle
// Notes: test clock stands still low between calls
`timescale 1ns/1ps
module bst_tester (
	output logic tck_out,
	output logic tms_out,
	output logic tdi_out,
	input wire logic tdo_in,
	input wire logic oe_in
);
	logic oe_seen = 1'b0;
	initial
	begin
		tck_out = 1'b0;
		tms_out = 1'b1;
		tdi_out = 1'b0;
	end
////////////////////////////////////////////////////////////////////////////
	task automatic step(input logic m, input logic d, output logic q);
		tms_out = m;
		tdi_out = d;
		#62.5 tck_out = 1'b1;
		// released serial out idles high through its pull-up
		q = oe_in ? tdo_in : 1'b1;
		oe_seen = oe_seen | oe_in;
		#62.5 tck_out = 1'b0;
	endtask : step
	task automatic walk(input logic [31:0] m, input logic [31:0] d, int n);
		logic q;
		for (int i = 0; i < n; i++)
			step(m[i], d[i], q);
	endtask : walk
	// lsb first out, tdi enters msb; last bit leaves shift
	task automatic scan(input logic ir, input logic [127:0] din, input int n,
		output logic [127:0] dout);
		logic q;
		dout = '0;
		step(1'b1, 1'b0, q);
		if (ir)
			step(1'b1, 1'b0, q);
		step(1'b0, 1'b0, q);
		step(1'b0, 1'b0, q);
		for (int i = 0; i < n; i++)
		begin
			step(i == n - 1, din[i], q);
			dout[i] = q;
		end
		step(1'b1, 1'b0, q);
		step(1'b0, 1'b0, q);
		tdi_out = ~din[n - 1];
	endtask : scan
endmodule : bst_tester

// File: tb/tb_boundary_scan_tap.sv
// Purpose: self-checking bench of the test access port
// Assumes: tester model owns the link clock, 125 ns period
// Notes: core side outputs are read after a short settle, except in t_id, which reads them right after its scan
`timescale 1ns/1ps
module tb_boundary_scan_tap;
	// 3'h5 is unused and must fall back to bypass
	localparam logic [20:0] CODES = {3'h5, bst_pkg::INS_BYPASS,
		bst_pkg::INS_HIGHZ, bst_pkg::INS_CLAMP, bst_pkg::INS_IDCODE,
		bst_pkg::INS_SAMPLE, bst_pkg::INS_EXTEST};
	logic core_clk_in, rst_n_in, test_reset_n_in, feature_set_select_in;
	logic tck, tms, tdi, tdo, oe, ovr, hz;
	logic [bst_pkg::BSR_W-1:0] pins, drive;
	logic [127:0] dout;
	int num_errors = 0;
	int n_checks = 0;
	bst_tap u_dut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
		.test_clock_in(tck), .test_reset_n_in(test_reset_n_in),
		.test_mode_select_in(tms), .test_serial_in_in(tdi),
		.feature_set_select_in(feature_set_select_in), .pin_sample_in(pins),
		.test_serial_out_out(tdo), .test_serial_out_oe_out(oe),
		.bsr_drive_out(drive), .pin_override_out(ovr), .pin_highz_out(hz));
	bst_tester u_tst (.tck_out(tck), .tms_out(tms), .tdi_out(tdi),
		.tdo_in(tdo), .oe_in(oe));
////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [127:0] got, input logic [127:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : check
	task automatic settle;
		repeat (6) @(posedge core_clk_in);
	endtask : settle
	task automatic t_id;
		u_tst.walk(32'h1F, 32'h0, 6);
		u_tst.scan(1'b0, '0, 32, dout);
		check(dout, 128'(bst_pkg::IDCODE_VALUE));
		check({ovr, hz, drive}, '0);
	endtask : t_id
	task automatic t_codes;
		logic [2:0] c;
		logic [125:0] d, prev, e;
		logic bs;
		for (int i = 0; i < 7; i++)
		begin
			c = CODES[3 * i +: 3];
			d = {21{6'(i * 9 + 5)}};
			bs = c == bst_pkg::INS_SAMPLE || c == bst_pkg::INS_EXTEST;
			@(posedge core_clk_in);
			pins <= ~d;
			prev = drive;
			u_tst.walk(32'h1F, 32'h0, 6);
			u_tst.scan(1'b1, 128'(c), 3, dout);
			check(dout, 128'(bst_pkg::IR_CAPTURE));
			e = bs ? ~d : (c == bst_pkg::INS_IDCODE ?
				126'(bst_pkg::IDCODE_VALUE) : 126'h0);
			e = e | (d << (bs ? 126 : (c == bst_pkg::INS_IDCODE ? 32 : 1)));
			u_tst.scan(1'b0, 128'(d), 126, dout);
			check(dout, 128'(e));
			settle();
			check({ovr, hz, drive}, {c == bst_pkg::INS_EXTEST ||
				c == bst_pkg::INS_CLAMP, c == bst_pkg::INS_HIGHZ,
				bs ? d : prev});
		end
	endtask : t_codes
	task automatic t_pause;
		u_tst.walk(32'h34E53, 32'h200, 19);
		settle();
		check(128'({ovr, hz}), 128'h1);
		u_tst.walk(32'h343, 32'h0, 11);
		settle();
		check(128'({ovr, hz}), 128'h2);
	endtask : t_pause
	task automatic t_fss;
		@(posedge core_clk_in);
		feature_set_select_in <= 1'b1;
		u_tst.oe_seen = 1'b0;
		u_tst.scan(1'b1, 128'(bst_pkg::INS_EXTEST), 3, dout);
		settle();
		check(128'({ovr, u_tst.oe_seen}), 128'h0);
		feature_set_select_in <= 1'b0;
		u_tst.walk(32'h1F, 32'h0, 6);
		u_tst.scan(1'b1, 128'(bst_pkg::INS_CLAMP), 3, dout);
		settle();
		check(128'({ovr, u_tst.oe_seen}), 128'h3);
	endtask : t_fss
	task automatic t_treset;
		@(posedge core_clk_in);
		test_reset_n_in <= 1'b0;
		@(posedge core_clk_in);
		test_reset_n_in <= 1'b1;
		u_tst.walk(32'h0, 32'h0, 1);
		u_tst.scan(1'b0, '0, 32, dout);
		settle();
		check(dout, 128'(bst_pkg::IDCODE_VALUE));
		check(128'(ovr), 128'h0);
	endtask : t_treset
	task automatic final_report;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : final_report
////////////////////////////////////////////////////////////////////////////
	initial
	begin
		core_clk_in = 1'b0;
		forever #5 core_clk_in = ~core_clk_in;
	end
	initial
	begin
		#400000;
		num_errors++;
		final_report();
	end
	initial
	begin
		rst_n_in = 1'b0;
		test_reset_n_in = 1'b0;
		feature_set_select_in = 1'b0;
		pins = '0;
		repeat (16) @(posedge core_clk_in);
		rst_n_in <= 1'b1;
		test_reset_n_in <= 1'b1;
		t_id();
		t_codes();
		t_pause();
		t_fss();
		t_treset();
		final_report();
	end
endmodule : tb_boundary_scan_tap
